// File: src/ilc_pkg.sv
package ilc_pkg;

   // Sources in fixed within-level order, index 0 wins a tie.
   localparam int NSRC = 14;
   localparam int SRC_W = 4;
   localparam int SRC_TRAP = 0;
   localparam int SRC_X0 = 1;
   localparam int SRC_T0 = 2;
   localparam int SRC_X1 = 3;
   localparam int SRC_T1 = 4;
   localparam int SRC_SER = 5;
   localparam int SRC_ADC = 6;
   localparam int SRC_CNT0 = 7;
   localparam int SRC_PLS = 8;
   localparam int SRC_CNT4 = 12;
   localparam int SRC_PF = 13;

   // Sources whose flag hardware drops on service; the pins depend on trigger type.
   localparam logic [NSRC-1:0] HW_CLR_MASK = 14'h0015;
   localparam logic [NSRC-1:0] EXT_MASK = 14'h000A;

   // Device register addresses on the register port.
   localparam logic [7:0] SFR_IE_LOW = 8'hA8;
   localparam logic [7:0] SFR_TCTL = 8'h88;
   localparam logic [7:0] SFR_REQ_LO = 8'hC0;
   localparam logic [7:0] SFR_REQ_HI = 8'hC1;

   // Enable register bit positions.
   localparam int EN_GLOBAL = 7;
   localparam int EN_COUNTER = 6;
   localparam int EN_ADC = 5;
   localparam int EN_SERIAL = 4;
   localparam int EN_T1 = 3;
   localparam int EN_X1 = 2;
   localparam int EN_T0 = 1;
   localparam int EN_X0 = 0;

   // Timer control register bit positions.
   localparam int TC_TT0 = 0;
   localparam int TC_RF0 = 1;
   localparam int TC_TT1 = 2;
   localparam int TC_RF1 = 3;

   // Pins are sampled once per frame of this many state times (one state per clock).
   localparam int SAMPLE_STATES = 4;
   localparam logic [2:0] TRAP_LEVEL = 3'h4;
   localparam logic [7:0] VEC_SEGMENT = 8'hFF;

   // Controller registers seen over AXI4-Lite.
   localparam logic [7:0] AX_CTRL = 8'h00;
   localparam logic [7:0] AX_SFR = 8'h04;
   localparam logic [7:0] AX_SET = 8'h08;
   localparam logic [7:0] AX_PRIO = 8'h0C;
   localparam logic [7:0] AX_STAT = 8'h10;
   localparam int CTRL_RTRN = 8;
   localparam int SFR_WE_BIT = 16;
   localparam int PRIO_HI_POS = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Vector offset inside the fixed segment for each source.
   function automatic logic [15:0] ilc_vector(input logic [SRC_W-1:0] src);
      case (src)
         4'h0: ilc_vector = 16'h007B;
         4'h1: ilc_vector = 16'h0003;
         4'h2: ilc_vector = 16'h000B;
         4'h3: ilc_vector = 16'h0013;
         4'h4: ilc_vector = 16'h001B;
         4'h5: ilc_vector = 16'h0023;
         4'h6: ilc_vector = 16'h002B;
         4'h7: ilc_vector = 16'h0033;
         4'h8: ilc_vector = 16'h0043;
         4'h9: ilc_vector = 16'h004B;
         4'hA: ilc_vector = 16'h0053;
         4'hB: ilc_vector = 16'h005B;
         4'hC: ilc_vector = 16'h0063;
         default: ilc_vector = 16'h0083;
      endcase
   endfunction : ilc_vector

endpackage : ilc_pkg

// File: src/ilc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ilc_if import ilc_pkg::*;;
   // Register port into the device.
   logic [7:0] sfr_addr;
   logic [7:0] sfr_wdata;
   logic sfr_we;
   logic [7:0] sfr_rdata;
   // Request sources.
   logic ext_irq_pin_zero;
   logic ext_irq_pin_one;
   logic [NSRC-1:0] periph_set;
   logic [NSRC-1:0] priority_high_bit;
   logic [NSRC-1:0] priority_low_bit;
   // Execution unit handshake.
   logic irq_valid;
   logic [15:0] irq_vector;
   logic [SRC_W-1:0] irq_source;
   logic irq_ack;
   logic return_from_interrupt;

   modport dev (
      input sfr_addr, sfr_wdata, sfr_we, ext_irq_pin_zero, ext_irq_pin_one, periph_set,
      input priority_high_bit, priority_low_bit, irq_ack, return_from_interrupt,
      output sfr_rdata, irq_valid, irq_vector, irq_source
   );
   modport cpu (
      output sfr_addr, sfr_wdata, sfr_we, ext_irq_pin_zero, ext_irq_pin_one, periph_set,
      output priority_high_bit, priority_low_bit, irq_ack, return_from_interrupt,
      input sfr_rdata, irq_valid, irq_vector, irq_source
   );
endinterface : ilc_if
`default_nettype wire

// File: src/ilc_device.sv
`timescale 1ns/1ps
`default_nettype none
module ilc_device import ilc_pkg::*; #(
   parameter int SAMPLE_PERIOD = SAMPLE_STATES
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Link to the execution unit and the requesters.
   ilc_if.dev link
);
   localparam int CW = $clog2(SAMPLE_PERIOD);

   if (SAMPLE_PERIOD < 2) begin : g_bad_period
      $error("SAMPLE_PERIOD must be at least 2");
   end

   logic [7:0] ie_q;
   logic [1:0] trig_q;
   logic [NSRC-1:0] req_q;
   logic [NSRC-1:0] req_d;
   logic [NSRC-1:0] set_v;
   logic [NSRC-1:0] hw_clr;
   logic [NSRC-1:0] sw_clr;
   logic [CW-1:0] fcnt_q;
   logic tick;
   logic [1:0] smp_q;
   logic [1:0] pins;
   logic [1:0] ext_evt;
   logic [NSRC-1:0] en;
   logic [NSRC-1:0] take;
   logic [2:0] lvl [NSRC];
   logic [4:0] active_q;
   logic cur_any;
   logic [2:0] cur_lvl;
   logic found;
   logic [SRC_W-1:0] best;
   logic [2:0] best_lvl;
   logic valid_q;
   logic [SRC_W-1:0] src_q;
   logic [15:0] vec_q;
   logic [2:0] sel_lvl_q;
   logic ack;
   logic [7:0] tctl_rd;

   assign pins = {link.ext_irq_pin_one, link.ext_irq_pin_zero};
   assign tick = fcnt_q == CW'(SAMPLE_PERIOD - 1);
   assign ack = valid_q & link.irq_ack;

   // Frame counter; a frame is the interrupt sampling cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fcnt_q <= '0;
      end else if (tick) begin
         fcnt_q <= '0;
      end else begin
         fcnt_q <= fcnt_q + CW'(1);
      end
   end

   // Pins are looked at only at frame ends, so a pulse shorter than a frame may be missed.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         smp_q <= 2'h3;
      end else if (tick) begin
         smp_q <= pins;
      end
   end

   // Level mode sees a low sample; edge mode sees high then low.
   always_comb begin
      for (int n = 0; n < 2; n++) begin
         ext_evt[n] = tick & ~pins[n] & (~trig_q[n] | smp_q[n]);
      end
   end

   // Software writes: enables and trigger types.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ie_q <= 8'h00;
         trig_q <= 2'h0;
      end else if (link.sfr_we && link.sfr_addr == SFR_IE_LOW) begin
         ie_q <= link.sfr_wdata;
      end else if (link.sfr_we && link.sfr_addr == SFR_TCTL) begin
         trig_q <= {link.sfr_wdata[TC_TT1], link.sfr_wdata[TC_TT0]};
      end
   end

   // Clear sources: service clears some flags, software clears the rest.
   always_comb begin
      sw_clr = '0;
      hw_clr = '0;
      set_v = link.periph_set & ~EXT_MASK;
      set_v[SRC_X0] = ext_evt[0];
      set_v[SRC_X1] = ext_evt[1];
      if (link.sfr_we && link.sfr_addr == SFR_REQ_LO) begin
         sw_clr[7:0] = link.sfr_wdata;
      end else if (link.sfr_we && link.sfr_addr == SFR_REQ_HI) begin
         sw_clr[NSRC-1:8] = link.sfr_wdata[NSRC-9:0];
      end else if (link.sfr_we && link.sfr_addr == SFR_TCTL) begin
         sw_clr[SRC_X0] = ~link.sfr_wdata[TC_RF0];
         sw_clr[SRC_X1] = ~link.sfr_wdata[TC_RF1];
      end
      for (int i = 0; i < NSRC; i++) begin
         if (ack && src_q == SRC_W'(i)) begin
            hw_clr[i] = HW_CLR_MASK[i];
         end
      end
      hw_clr[SRC_X0] = hw_clr[SRC_X0] | (ack && src_q == SRC_W'(SRC_X0) && trig_q[0]);
      hw_clr[SRC_X1] = hw_clr[SRC_X1] | (ack && src_q == SRC_W'(SRC_X1) && trig_q[1]);
      req_d = (req_q & ~(hw_clr | sw_clr)) | set_v;
   end

   // Request flags; a set in the clearing cycle wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_q <= '0;
      end else begin
         req_q <= req_d;
      end
   end

   // Enable map; counters and pulse unit share one bit, power-fail needs only global.
   always_comb begin
      en = '0;
      en[SRC_TRAP] = 1'b1;
      en[SRC_X0] = ie_q[EN_X0];
      en[SRC_T0] = ie_q[EN_T0];
      en[SRC_X1] = ie_q[EN_X1];
      en[SRC_T1] = ie_q[EN_T1];
      en[SRC_SER] = ie_q[EN_SERIAL];
      en[SRC_ADC] = ie_q[EN_ADC];
      for (int i = SRC_CNT0; i <= SRC_CNT4; i++) begin
         en[i] = ie_q[EN_COUNTER];
      end
      en[SRC_PF] = 1'b1;
   end

   // Current level is the highest one marked in progress.
   always_comb begin
      cur_any = |active_q;
      cur_lvl = 3'h0;
      for (int l = 0; l < 5; l++) begin
         if (active_q[l]) begin
            cur_lvl = 3'(l);
         end
      end
   end

   // Per-source level, gating and within-level resolver.
   always_comb begin
      found = 1'b0;
      best = '0;
      best_lvl = 3'h0;
      for (int i = 0; i < NSRC; i++) begin
         lvl[i] = {1'b0, link.priority_high_bit[i], link.priority_low_bit[i]};
         if (i == SRC_TRAP) begin
            lvl[i] = TRAP_LEVEL;
         end
         take[i] = req_q[i] && en[i] && (i == SRC_TRAP || ie_q[EN_GLOBAL])
            && (!cur_any || lvl[i] > cur_lvl);
         if (take[i] && (!found || lvl[i] > best_lvl)) begin
            found = 1'b1;
            best = SRC_W'(i);
            best_lvl = lvl[i];
         end
      end
   end

   // Offer one winner per frame and hold it until the execution unit takes it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         valid_q <= 1'b0;
         src_q <= '0;
         vec_q <= 16'h0000;
         sel_lvl_q <= 3'h0;
      end else if (ack) begin
         valid_q <= 1'b0;
      end else if (tick && !valid_q && found) begin
         valid_q <= 1'b1;
         src_q <= best;
         vec_q <= ilc_vector(best);
         sel_lvl_q <= best_lvl;
      end
   end

   // In-progress levels; return drops the top one before a new accept is marked.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_q <= 5'h00;
      end else begin
         active_q <= (link.return_from_interrupt ? (active_q & ~(5'h01 << cur_lvl)) : active_q)
            | (ack ? (5'h01 << sel_lvl_q) : 5'h00);
      end
   end

   // Register read port.
   always_comb begin
      tctl_rd = 8'h00;
      tctl_rd[TC_TT0] = trig_q[0];
      tctl_rd[TC_RF0] = req_q[SRC_X0];
      tctl_rd[TC_TT1] = trig_q[1];
      tctl_rd[TC_RF1] = req_q[SRC_X1];
      if (link.sfr_addr == SFR_IE_LOW) begin
         link.sfr_rdata = ie_q;
      end else if (link.sfr_addr == SFR_TCTL) begin
         link.sfr_rdata = tctl_rd;
      end else if (link.sfr_addr == SFR_REQ_LO) begin
         link.sfr_rdata = req_q[7:0];
      end else if (link.sfr_addr == SFR_REQ_HI) begin
         link.sfr_rdata = 8'(req_q[NSRC-1:8]);
      end else begin
         link.sfr_rdata = 8'h00;
      end
   end

   assign link.irq_valid = valid_q;
   assign link.irq_vector = vec_q;
   assign link.irq_source = src_q;

endmodule : ilc_device
`default_nettype wire

// File: src/ilc_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module ilc_cpu import ilc_pkg::*; #(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave.
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Link to the interrupt controller.
   ilc_if.cpu link
);
   if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8");
   end

   logic aw_have_q;
   logic w_have_q;
   logic [7:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] s_q;
   logic do_wr;
   logic [31:0] wm;
   logic [1:0] pin_q;
   logic [7:0] sfr_addr_q;
   logic [7:0] sfr_wdata_q;
   logic sfr_we_q;
   logic [NSRC-1:0] set_q;
   logic rtn_q;
   logic [31:0] prio_q;
   logic [15:0] last_vec_q;
   logic [SRC_W-1:0] last_src_q;
   logic [2:0] depth_q;
   logic [31:0] rd;
   logic rd_ok;
   logic wr_ok;

   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_wr = aw_have_q && w_have_q;
   assign wr_ok = aw_q == AX_CTRL || aw_q == AX_SFR || aw_q == AX_SET || aw_q == AX_PRIO;

   // Address and data are caught independently, in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= 8'h00;
         w_q <= 32'h0000_0000;
         s_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_q <= s_axi_awaddr[7:0];
         end else if (do_wr) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_q <= s_axi_wdata;
            s_q <= s_axi_wstrb;
         end else if (do_wr) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // Byte-lane mask from the strobes.
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wm[8*b +: 8] = {8{s_q[b]}};
      end
   end

   // Write response one cycle after both halves are held.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Held settings: pin levels, priorities and register port address.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_q <= 2'h3;
         prio_q <= 32'h0000_0000;
         sfr_addr_q <= 8'h00;
         sfr_wdata_q <= 8'h00;
      end else if (do_wr && aw_q == AX_CTRL) begin
         pin_q <= (pin_q & ~wm[1:0]) | (w_q[1:0] & wm[1:0]);
      end else if (do_wr && aw_q == AX_PRIO) begin
         prio_q <= (prio_q & ~wm) | (w_q & wm);
      end else if (do_wr && aw_q == AX_SFR) begin
         sfr_addr_q <= w_q[15:8];
         sfr_wdata_q <= w_q[7:0];
      end
   end

   // One-cycle strobes toward the controller.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sfr_we_q <= 1'b0;
         set_q <= '0;
         rtn_q <= 1'b0;
      end else begin
         sfr_we_q <= do_wr && aw_q == AX_SFR && w_q[SFR_WE_BIT] && s_q[2];
         set_q <= (do_wr && aw_q == AX_SET) ? (w_q[NSRC-1:0] & wm[NSRC-1:0]) : '0;
         rtn_q <= do_wr && aw_q == AX_CTRL && w_q[CTRL_RTRN] && s_q[1];
      end
   end

   // The unit finishes its instruction at once, so every offer is taken on sight.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_vec_q <= 16'h0000;
         last_src_q <= '0;
         depth_q <= 3'h0;
      end else begin
         if (link.irq_valid) begin
            last_vec_q <= link.irq_vector;
            last_src_q <= link.irq_source;
         end
         depth_q <= depth_q + 3'(link.irq_valid) - 3'(rtn_q && depth_q != 3'h0);
      end
   end

   // Read decode.
   always_comb begin
      rd_ok = 1'b1;
      rd = 32'h0000_0000;
      if (s_axi_araddr[7:0] == AX_CTRL) begin
         rd[1:0] = pin_q;
      end else if (s_axi_araddr[7:0] == AX_SFR) begin
         rd[15:0] = {sfr_addr_q, link.sfr_rdata};
      end else if (s_axi_araddr[7:0] == AX_PRIO) begin
         rd = prio_q;
      end else if (s_axi_araddr[7:0] == AX_STAT) begin
         rd = {8'h00, 1'b0, depth_q, last_src_q, last_vec_q};
      end else begin
         rd_ok = 1'b0;
      end
   end

   // Read data registered one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign link.sfr_addr = sfr_addr_q;
   assign link.sfr_wdata = sfr_wdata_q;
   assign link.sfr_we = sfr_we_q;
   assign link.ext_irq_pin_zero = pin_q[0];
   assign link.ext_irq_pin_one = pin_q[1];
   assign link.periph_set = set_q;
   assign link.priority_low_bit = prio_q[NSRC-1:0];
   assign link.priority_high_bit = prio_q[PRIO_HI_POS +: NSRC];
   assign link.irq_ack = link.irq_valid;
   assign link.return_from_interrupt = rtn_q;

endmodule : ilc_cpu
`default_nettype wire

// File: dv/ilc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ilc_sva import ilc_pkg::*; (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Device register port.
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_we,
   input wire logic [7:0] sfr_rdata,
   // Levels, offers and returns.
   input wire logic [NSRC-1:0] priority_high_bit,
   input wire logic [NSRC-1:0] priority_low_bit,
   input wire logic irq_valid,
   input wire logic [15:0] irq_vector,
   input wire logic [SRC_W-1:0] irq_source,
   input wire logic irq_ack,
   input wire logic return_from_interrupt
);
   logic [7:0] en_q;
   logic [2:0] stk_q [8];
   logic [2:0] dep_q;
   logic [2:0] dep_d;
   logic [2:0] top;
   logic [2:0] lvl;
   logic [15:0] exp_vec;
   logic [1:0] ph_q;
   logic seen_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Shadow of the enable register, so gating is judged without the device's internals.
   always_ff @(posedge aclk) begin
      if (!aresetn) en_q <= 8'h00;
      else if (sfr_we && sfr_addr == SFR_IE_LOW) en_q <= sfr_wdata;
   end

   // Level of the current offer; the trap sits above every programmable level.
   assign lvl = (irq_source == SRC_TRAP) ? TRAP_LEVEL :
      {1'b0, priority_high_bit[irq_source], priority_low_bit[irq_source]};
   // Vectors climb in 8-byte steps, skipping the slot that the pulse unit jumps over.
   assign exp_vec = (irq_source == SRC_TRAP) ? 16'h007B : (irq_source == SRC_PF) ? 16'h0083 :
      (irq_source < SRC_PLS) ? 16'h0003 + {9'h0, irq_source, 3'h0} - 16'h0008 :
      16'h0003 + {9'h0, irq_source, 3'h0};

   // In-progress stack; a return pops before a same-cycle acknowledge pushes.
   assign dep_d = dep_q - {2'h0, return_from_interrupt && dep_q != 3'h0};
   assign top = (dep_q == 3'h0) ? 3'h0 : stk_q[dep_q - 3'h1];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dep_q <= 3'h0;
      end else begin
         if (irq_ack) stk_q[dep_d] <= lvl;
         dep_q <= dep_d + {2'h0, irq_ack};
      end
   end

   // Phase since the last offer; offers may only start on frame boundaries.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ph_q <= 2'h0;
         seen_q <= 1'b0;
      end else begin
         ph_q <= $rose(irq_valid) ? 2'h1 : ph_q + 2'h1;
         seen_q <= seen_q | $rose(irq_valid);
      end
   end

   sequence offer_s;
      irq_valid && irq_ack;
   endsequence
   sequence quiet_s;
      !irq_valid [*3];
   endsequence

   offer_gap_a: assert property (offer_s |=> quiet_s)
      else $error("offer not followed by a quiet frame");
   vector_map_a: assert property (irq_valid |-> irq_vector == exp_vec)
      else $error("vector does not match source");
   global_gate_a: assert property (irq_valid && irq_source != SRC_TRAP |->
      ($past(en_q) & 8'h80) != 8'h00) else $error("offer with global enable off");
   ext0_gate_a: assert property (irq_valid && irq_source == SRC_X0 |->
      ($past(en_q) & 8'h01) != 8'h00) else $error("pin zero offered while disabled");
   ext1_gate_a: assert property (irq_valid && irq_source == SRC_X1 |->
      ($past(en_q) & 8'h04) != 8'h00) else $error("pin one offered while disabled");
   strict_preempt_a: assert property (irq_valid |->
      $past(dep_q) == 3'h0 || lvl > $past(top)) else $error("offer not above level in progress");
   frame_phase_a: assert property ($rose(irq_valid) && seen_q |-> ph_q == 2'h0)
      else $error("offer off the frame boundary");
   enable_read_a: assert property (sfr_addr == SFR_IE_LOW |-> sfr_rdata == en_q)
      else $error("enable register read differs from writes");
endmodule : ilc_sva
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb import ilc_pkg::*;;
   typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} ilc_note_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, last_rd, prio;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, e_b;
   logic [31:0] rdata;
   logic [1:0] pins = 2'h3;
   ilc_note_t rq[$];
   ilc_note_t e_rd;
   logic [1:0] bq[$];
   int n_mismatch = 0;
   int checked = 0;

   always #2 aclk = ~aclk;

   ilc_if link_if ();
   ilc_cpu ilc_cpu_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link(link_if));
   ilc_device ilc_device_inst (.aclk(aclk), .aresetn(aresetn), .link(link_if));
   ilc_sva ilc_sva_inst (.aclk(aclk), .aresetn(aresetn), .sfr_addr(link_if.sfr_addr),
      .sfr_wdata(link_if.sfr_wdata), .sfr_we(link_if.sfr_we), .sfr_rdata(link_if.sfr_rdata),
      .priority_high_bit(link_if.priority_high_bit), .priority_low_bit(link_if.priority_low_bit),
      .irq_valid(link_if.irq_valid), .irq_vector(link_if.irq_vector),
      .irq_source(link_if.irq_source), .irq_ack(link_if.irq_ack),
      .return_from_interrupt(link_if.return_from_interrupt));

   // Responses are matched in order against the notes the drivers left; a zero mask is a poll.
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         e_rd = rq.pop_front();
         if (e_rd.m != 32'h0) begin
            `CHK(rdata & e_rd.m, e_rd.d)
            `CHK(rresp, e_rd.r)
         end
      end
      // The note is popped once, so a mismatch message cannot pop a second one.
      if (bvalid && bready) begin
         e_b = bq.pop_front();
         `CHK(bresp, e_b)
      end
   end

   // Write: address and data offered together, each dropped when taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid) @(posedge aclk);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] r);
      @(posedge aclk);
      rq.push_back('{d, m, r});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge aclk);
      last_rd = rdata;
      rready <= 1'b0;
   endtask : rd

   task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
      wr(AX_SFR, {15'h0, 1'b1, a, d}, RESP_OKAY);
   endtask : sfr_w

   // Points the register port at an address without a strobe, then reads it back.
   task automatic sfr_chk(input logic [7:0] a, input logic [7:0] d);
      wr(AX_SFR, {16'h0, a, 8'h00}, RESP_OKAY);
      rd(AX_SFR, {16'h0, a, d}, 32'h0000FFFF, RESP_OKAY);
   endtask : sfr_chk

   task automatic ctrl(input logic ret);
      wr(AX_CTRL, {23'h0, ret, 6'h0, pins}, RESP_OKAY);
   endtask : ctrl

   // Polls status until the vector shows, then checks depth, source and vector together.
   task automatic wait_vec(input logic [15:0] v, input logic [3:0] s, input logic [2:0] dp);
      last_rd = 32'hFFFFFFFF;
      for (int i = 0; i < 200 && last_rd[15:0] !== v; i++) rd(AX_STAT, 32'h0, 32'h0, RESP_OKAY);
      rd(AX_STAT, {9'h0, dp, s, v}, 32'h007FFFFF, RESP_OKAY);
   endtask : wait_vec

   task automatic end_sim();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   // Bounds the whole run well above the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      end_sim();
   end

   initial begin
      void'($urandom(32'h57ca9789));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      sfr_chk(SFR_IE_LOW, 8'h00);
      rd(8'h14, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
      rd(AX_SET, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
      wr(8'h14, 32'h0, RESP_SLVERR);
      prio = $urandom & 32'h3FFF3FFF;
      wr(AX_PRIO, prio, RESP_OKAY);
      rd(AX_PRIO, prio, 32'h3FFF3FFF, RESP_OKAY);
      prio = {24'h0, 1'b0, 7'($urandom)};
      sfr_w(SFR_IE_LOW, prio[7:0]);
      sfr_chk(SFR_IE_LOW, prio[7:0]);
      $display("done: registers");
      // Serial request with its own enable but the global one off must wait.
      sfr_w(SFR_IE_LOW, 8'h10);
      wr(AX_SET, 32'h20, RESP_OKAY);
      repeat (4 * SAMPLE_STATES) @(posedge aclk);
      rd(AX_STAT, 32'h0, 32'h00700000, RESP_OKAY);
      sfr_w(SFR_IE_LOW, 8'h90);
      wait_vec(16'h0023, 4'h5, 3'h1);
      sfr_chk(SFR_REQ_LO, 8'h20);
      sfr_w(SFR_REQ_LO, 8'h20);
      ctrl(1'b1);
      $display("done: global enable");
      // Edge pin flags even while disabled, then is taken once enabled.
      sfr_w(SFR_IE_LOW, 8'h80);
      sfr_w(SFR_TCTL, 8'h01);
      pins = 2'h2;
      ctrl(1'b0);
      repeat (8 * SAMPLE_STATES) @(posedge aclk);
      sfr_chk(SFR_TCTL, 8'h03);
      rd(AX_STAT, 32'h0, 32'h00700000, RESP_OKAY);
      sfr_w(SFR_IE_LOW, 8'h81);
      wait_vec(16'h0003, 4'h1, 3'h1);
      sfr_chk(SFR_TCTL, 8'h01);
      pins = 2'h3;
      ctrl(1'b0);
      ctrl(1'b1);
      $display("done: edge pin");
      // Level pin keeps its flag after service until software clears it.
      sfr_w(SFR_TCTL, 8'h00);
      sfr_w(SFR_IE_LOW, 8'h84);
      pins = 2'h1;
      ctrl(1'b0);
      wait_vec(16'h0013, 4'h3, 3'h1);
      pins = 2'h3;
      ctrl(1'b0);
      sfr_chk(SFR_TCTL, 8'h08);
      sfr_w(SFR_TCTL, 8'h00);
      ctrl(1'b1);
      $display("done: level pin");
      // Timer 0 at level 1, power-fail at level 3, the rest at level 0.
      wr(AX_PRIO, 32'h20002004, RESP_OKAY);
      sfr_w(SFR_IE_LOW, 8'hFF);
      wr(AX_SET, 32'h34, RESP_OKAY);
      wait_vec(16'h000B, 4'h2, 3'h1);
      wr(AX_SET, 32'h2000, RESP_OKAY);
      wait_vec(16'h0083, 4'hD, 3'h2);
      // Power-fail is cleared before its return, or it is offered again above level one.
      sfr_chk(SFR_REQ_HI, 8'h20);
      sfr_w(SFR_REQ_HI, 8'h20);
      ctrl(1'b1);
      ctrl(1'b1);
      wait_vec(16'h001B, 4'h4, 3'h1);
      sfr_chk(SFR_REQ_LO, 8'h20);
      ctrl(1'b1);
      wait_vec(16'h0023, 4'h5, 3'h1);
      sfr_w(SFR_REQ_LO, 8'h20);
      ctrl(1'b1);
      $display("done: priorities");
      // The trap is taken with every enable off.
      sfr_w(SFR_IE_LOW, 8'h00);
      wr(AX_SET, 32'h1, RESP_OKAY);
      wait_vec(16'h007B, 4'h0, 3'h1);
      ctrl(1'b1);
      $display("done: trap");
      end_sim();
   end
endmodule : tb
`default_nettype wire
